// ==== pin_function_multiplexer.sv ====
// pin function multiplexer: port bits versus bus, serial and CAN functions
//
// How it works
// [RULE1] port 0: gpio, or bus low byte
// [RULE2] port 1: gpio, or bus high byte
// [RULE3] port 2 bit: gpio if enable set, else address
// [RULE4] port 3 bit 0: latch enable on bus
// [RULE5] port 3 bit 1: read strobe on bus
// [RULE6] port 3 bit 2: low write strobe if enabled
// [RULE7] port 3 bit 3: high strobe, 16-bit only
// [RULE8] port 3 bit 4: hold request input if enabled
// [RULE9] port 3 bit 5: hold grant output if enabled
// [RULE10] port 3 bit 6: ready input if enabled
// [RULE11] port 3 bit 7: clock output if enabled
// [RULE12] port 4 bit 0: serial 0 transmit
// [RULE13] port 4 bit 1: serial 0 clock output
// [RULE14] serial receive pins stay gpio, software sets input
// [RULE15] port 9 bit 6: CAN 1 transmit
// [RULE16] software keeps other drivers off CAN receive
// [RULE17] ports 0-3 gpio bits have pullup control
// [RULE18] operating mode from three static mode pins
// [RULE19] reset pin and standby pin are requests
// [RULE20] unowned pins follow data and direction
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module pin_function_multiplexer
  import pinmux_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [2:0] modeSel,
  input wire logic standbyPin,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire ext_bus_t busOut,
  input wire periph_out_t periphOut,
  output periph_in_t periphIn,
  input wire logic [NUM_PORTS-1:0][7:0] pinIn,
  output logic [NUM_PORTS-1:0][7:0] pinOut,
  output logic [NUM_PORTS-1:0][7:0] pinOe,
  output logic [NUM_PULL_PORTS-1:0][7:0] pullupEn,
  output logic standbyRequest,
  output logic extBusActive
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] busCtrl;
    logic [7:0] highAddrEn;
    logic [7:0] rdata;
    pin_drive_t [NUM_PORTS-1:0] drv;
    logic [NUM_PULL_PORTS-1:0][7:0] pull;
    periph_in_t toCore;
  } mux_t;

  mux_t q, d;
  reg_req_t req;
  logic rstSyncN;
  logic extBus;
  logic [NUM_PORTS-1:0][7:0] portData;
  logic [NUM_PORTS-1:0][7:0] portDir;
  logic [NUM_PULL_PORTS-1:0][7:0] portPull;

  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  mode_strap u_strap (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .modeSel(modeSel),
    .standbyPin(standbyPin),
    .rstSyncN(rstSyncN),
    .extBusEn(extBus),
    .standbyReq(standbyRequest)
  );

  port_bank u_bank (
    .core_clk(core_clk),
    .rstSyncN(rstSyncN),
    .req(req),
    .data(portData),
    .dir(portDir),
    .pull(portPull)
  );

  // ****************************************
  // registers and pin routing
  // ****************************************
  always_comb begin
    logic [3:0] slot;
    logic lowWrOn;
    logic highWrOn;
    logic holdOn;
    logic readyOn;
    logic clkOn;
    logic [NUM_PULL_PORTS-1:0][7:0] owned;
    d = q;
    slot = portSlot(req.addr - ADDR_DATA0);
    lowWrOn = extBus && q.busCtrl[BC_LOW_WR_EN];
    highWrOn = extBus && q.busCtrl[BC_BUS16] && q.busCtrl[BC_HIGH_WR_EN];
    holdOn = extBus && q.busCtrl[BC_HOLD_EN];
    readyOn = extBus && q.busCtrl[BC_READY_EN];
    clkOn = extBus && q.busCtrl[BC_CLK_OUT_EN];
    owned = '0;

    if (req.wr && req.addr == ADDR_HIGH_ADDR_EN) begin
      d.highAddrEn = req.wdata;
    end
    if (req.wr && req.addr == ADDR_BUS_CTRL) begin
      d.busCtrl = req.wdata;
    end

    // data reads return the pin for input bits, the latch for outputs
    d.rdata = 8'h00;
    if (req.rd) begin
      if (slot != SLOT_NONE) begin
        d.rdata = (portData[slot] & portDir[slot]) | (pinIn[slot] & ~portDir[slot]);
      end else if (portSlot(req.addr - ADDR_DIR0) != SLOT_NONE) begin
        d.rdata = portDir[portSlot(req.addr - ADDR_DIR0)];
      end else if (req.addr >= ADDR_PULL0 &&
                   req.addr < ADDR_PULL0 + 8'(NUM_PULL_PORTS)) begin
        d.rdata = portPull[2'(req.addr - ADDR_PULL0)];
      end
    end

    for (int p = 0; p < NUM_PORTS; p++) begin
      d.drv[p].out = portData[p]; // [RULE20]
      d.drv[p].oe = portDir[p]; // [RULE20]
    end

    if (extBus) begin
      d.drv[0].out = busOut.adOut[7:0]; // [RULE1]
      d.drv[0].oe = {8{busOut.adOe}}; // [RULE1]
      d.drv[1].out = busOut.adOut[15:8]; // [RULE2]
      d.drv[1].oe = {8{busOut.adOe}}; // [RULE2]
      owned[0] = 8'hFF;
      owned[1] = 8'hFF;
      for (int b = 0; b < 8; b++) begin
        if (!q.highAddrEn[b]) begin
          d.drv[2].out[b] = busOut.upperAddr[b]; // [RULE3]
          d.drv[2].oe[b] = 1'b1; // [RULE3]
          owned[2][b] = 1'b1;
        end
      end
      d.drv[3].out[1:0] = {busOut.readStrobe, busOut.addrLatch}; // [RULE4] [RULE5]
      d.drv[3].oe[1:0] = 2'h3; // [RULE4] [RULE5]
      owned[3][1:0] = 2'h3;
    end
    // one strobe serves the low byte of 16-bit and the only byte of 8-bit
    if (lowWrOn) begin
      d.drv[3].out[2] = busOut.lowWrite; // [RULE6]
      d.drv[3].oe[2] = 1'b1; // [RULE6]
      owned[3][2] = 1'b1;
    end
    if (highWrOn) begin
      d.drv[3].out[3] = busOut.highWrite; // [RULE7]
      d.drv[3].oe[3] = 1'b1; // [RULE7]
      owned[3][3] = 1'b1;
    end
    if (holdOn) begin
      d.drv[3].oe[4] = 1'b0; // [RULE8]
      d.drv[3].out[5] = busOut.holdGrant; // [RULE9]
      d.drv[3].oe[5] = 1'b1; // [RULE9]
      owned[3][5:4] = 2'h3;
    end
    if (readyOn) begin
      d.drv[3].oe[6] = 1'b0; // [RULE10]
      owned[3][6] = 1'b1;
    end
    if (clkOn) begin
      d.drv[3].out[7] = busOut.busClk; // [RULE11]
      d.drv[3].oe[7] = 1'b1; // [RULE11]
      owned[3][7] = 1'b1;
    end
    if (periphOut.ser0TxEn) begin
      d.drv[4].out[0] = periphOut.ser0Tx; // [RULE12]
      d.drv[4].oe[0] = 1'b1; // [RULE12]
    end
    if (periphOut.ser0ClkEn) begin
      d.drv[4].out[1] = periphOut.ser0ClkOut; // [RULE13]
      d.drv[4].oe[1] = 1'b1; // [RULE13]
    end
    if (periphOut.can1TxEn) begin
      d.drv[SLOT_PORT9].out[6] = periphOut.can1Tx; // [RULE15]
      d.drv[SLOT_PORT9].oe[6] = 1'b1; // [RULE15]
    end

    // pullups only on gpio bits that are inputs, never against a driver
    for (int p = 0; p < NUM_PULL_PORTS; p++) begin
      d.pull[p] = portPull[p] & ~d.drv[p].oe & ~owned[p]; // [RULE17]
    end

    d.toCore.adIn = {pinIn[1], pinIn[0]};
    d.toCore.holdRequest = holdOn && pinIn[3][4]; // [RULE8]
    // ready defaults high so that a disabled ready input never stalls
    d.toCore.readyIn = readyOn ? pinIn[3][6] : 1'b1; // [RULE10]
    d.toCore.ser0ClkIn = pinIn[4][1];
    // receive paths are plain taps on the pin input
    d.toCore.ser0RxIn = pinIn[4][2]; // [RULE14]
    d.toCore.ser1RxIn = pinIn[4][3]; // [RULE14]
    d.toCore.can0Rx = pinIn[SLOT_PORT9][5]; // [RULE16]
    d.toCore.can1Rx = pinIn[SLOT_PORT9][7]; // [RULE16]
  end

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      q <= '0;
      q.busCtrl <= RST_BUS_CTRL;
      q.highAddrEn <= RST_HIGH_ADDR_EN;
      q.toCore.readyIn <= 1'b1;
    end else begin
      q <= d;
    end
  end

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      pinOut[p] = q.drv[p].out;
      pinOe[p] = q.drv[p].oe;
    end
  end

  assign pullupEn = q.pull;
  assign periphIn = q.toCore;
  assign regRdata = q.rdata;
  assign extBusActive = extBus;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstSyncN);

  property p_low_bus;
    extBus ##1 extBus |-> pinOut[0] == $past(busOut.adOut[7:0])
      && pinOe[0] == {8{$past(busOut.adOe)}};
  endproperty
  a_low_bus: assert property (p_low_bus) else $error("port 0 not on bus"); // [RULE1]

  property p_high_bus;
    extBus ##1 extBus |-> pinOut[1] == $past(busOut.adOut[15:8]);
  endproperty
  a_high_bus: assert property (p_high_bus) else $error("port 1 not on bus"); // [RULE2]

  property p_upper_addr;
    extBus ##1 extBus |->
      ((pinOut[2] ^ $past(busOut.upperAddr)) & ~$past(q.highAddrEn)) == 8'h00;
  endproperty
  a_upper_addr: assert property (p_upper_addr) else $error("address bits wrong"); // [RULE3]

  property p_strobes;
    extBus ##1 extBus |-> pinOe[3][1:0] == 2'h3
      && pinOut[3][1:0] == {$past(busOut.readStrobe), $past(busOut.addrLatch)};
  endproperty
  a_strobes: assert property (p_strobes) else $error("latch or read bad"); // [RULE4] [RULE5]

  property p_low_wr;
    extBus && q.busCtrl[BC_LOW_WR_EN] |=> pinOut[3][2] == $past(busOut.lowWrite);
  endproperty
  a_low_wr: assert property (p_low_wr) else $error("low write bad"); // [RULE6]

  property p_high_wr_off;
    !(extBus && q.busCtrl[BC_BUS16] && q.busCtrl[BC_HIGH_WR_EN])
      |=> pinOe[3][3] == $past(portDir[3][3]);
  endproperty
  a_high_wr_off: assert property (p_high_wr_off) else $error("high write leaked"); // [RULE7]

  property p_hold_req;
    !(extBus && q.busCtrl[BC_HOLD_EN]) |=> !periphIn.holdRequest;
  endproperty
  a_hold_req: assert property (p_hold_req) else $error("hold request leaked"); // [RULE8]

  property p_ready;
    !(extBus && q.busCtrl[BC_READY_EN]) |=> periphIn.readyIn;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not high"); // [RULE10]

  property p_ser_tx;
    periphOut.ser0TxEn |=> pinOe[4][0] && pinOut[4][0] == $past(periphOut.ser0Tx);
  endproperty
  a_ser_tx: assert property (p_ser_tx) else $error("serial tx bad"); // [RULE12]

  property p_can_tx;
    !periphOut.can1TxEn |=> pinOe[SLOT_PORT9][6] == $past(portDir[SLOT_PORT9][6]);
  endproperty
  a_can_tx: assert property (p_can_tx) else $error("can tx leaked"); // [RULE15]

  property p_pull;
    (pullupEn[0] & pinOe[0]) == 8'h00 && (pullupEn[3] & pinOe[3]) == 8'h00;
  endproperty
  a_pull: assert property (p_pull) else $error("pullup on driver"); // [RULE17]

  property p_gpio;
    1'b1 |=> pinOe[4][7:4] == $past(portDir[4][7:4])
      && pinOut[4][7:4] == $past(portData[4][7:4]);
  endproperty
  a_gpio: assert property (p_gpio) else $error("gpio drive bad"); // [RULE20]

  property p_standby;
    standbyPin |=> standbyRequest;
  endproperty
  a_standby: assert property (p_standby) else $error("standby lost"); // [RULE19]

endmodule : pin_function_multiplexer
`default_nettype wire

// ==== pinmux_pkg.sv ====
// shared constants, carrier types and decode helpers of the pin multiplexer
package pinmux_pkg;

  localparam int NUM_PORTS = 6;
  localparam int NUM_PULL_PORTS = 4;
  localparam int SLOT_PORT9 = 5;
  localparam logic [3:0] SLOT_NONE = 4'hF;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] ADDR_DATA0 = 8'h00;
  localparam logic [7:0] ADDR_DATA9 = 8'h09;
  localparam logic [7:0] ADDR_DIR0 = 8'h10;
  localparam logic [7:0] ADDR_PULL0 = 8'h1C;
  localparam logic [7:0] ADDR_HIGH_ADDR_EN = 8'hA6;
  localparam logic [7:0] ADDR_BUS_CTRL = 8'hA7;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] RST_PULL = 8'h00;
  localparam logic [7:0] RST_HIGH_ADDR_EN = 8'h00;
  localparam logic [7:0] RST_BUS_CTRL = 8'h00;
  localparam logic [2:0] MODE_SINGLE_CHIP = 3'h3;

  // ****************************************
  // bus control field positions
  // ****************************************
  localparam int BC_LOW_WR_EN = 0;
  localparam int BC_HIGH_WR_EN = 1;
  localparam int BC_HOLD_EN = 2;
  localparam int BC_READY_EN = 3;
  localparam int BC_CLK_OUT_EN = 4;
  localparam int BC_BUS16 = 5;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_t;

  // driven by the bus interface of the core
  typedef struct packed {
    logic [15:0] adOut;
    logic adOe;
    logic [7:0] upperAddr;
    logic addrLatch;
    logic readStrobe;
    logic lowWrite;
    logic highWrite;
    logic holdGrant;
    logic busClk;
  } ext_bus_t;

  typedef struct packed {
    logic ser0Tx;
    logic ser0TxEn;
    logic ser0ClkOut;
    logic ser0ClkEn;
    logic can1Tx;
    logic can1TxEn;
  } periph_out_t;

  typedef struct packed {
    logic [15:0] adIn;
    logic holdRequest;
    logic readyIn;
    logic ser0ClkIn;
    logic ser0RxIn;
    logic ser1RxIn;
    logic can0Rx;
    logic can1Rx;
  } periph_in_t;

  // port data offset to storage slot; port 9 sits after port 4
  function automatic logic [3:0] portSlot(input logic [7:0] off);
    if (off < 8'h05) begin
      portSlot = off[3:0];
    end else if (off == ADDR_DATA9) begin
      portSlot = 4'(SLOT_PORT9);
    end else begin
      portSlot = SLOT_NONE;
    end
  endfunction : portSlot

endpackage : pinmux_pkg

// ==== mode_strap.sv ====
// reset release, mode capture and standby request
`timescale 1ns/1ns
`default_nettype none
module mode_strap
  import pinmux_pkg::*;
#(
  parameter logic [2:0] SINGLE_CHIP = MODE_SINGLE_CHIP
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [2:0] modeSel,
  input wire logic standbyPin,
  output logic rstSyncN,
  output logic extBusEn,
  output logic standbyReq
);

  typedef struct packed {
    logic captured;
    logic extBus;
    logic standby;
  } strap_t;

  logic [1:0] syncQ;
  strap_t q, d;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncQ <= 2'h0;
    end else begin
      syncQ <= {syncQ[0], 1'b1};
    end
  end

  assign rstSyncN = syncQ[1];

  // mode pins are caught once, after release; they are static straps
  always_comb begin
    d = q;
    d.standby = standbyPin; // [RULE19]
    if (!q.captured) begin
      d.captured = 1'b1;
      d.extBus = (modeSel != SINGLE_CHIP); // [RULE18]
    end
  end

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign extBusEn = q.extBus;
  assign standbyReq = q.standby;

endmodule : mode_strap
`default_nettype wire

// ==== port_bank.sv ====
// port data, direction and pullup registers
`timescale 1ns/1ns
`default_nettype none
module port_bank
  import pinmux_pkg::*;
#(
  parameter int PORTS = NUM_PORTS,
  parameter int PULLS = NUM_PULL_PORTS
) (
  input wire logic core_clk,
  input wire logic rstSyncN,
  input wire reg_req_t req,
  output logic [PORTS-1:0][7:0] data,
  output logic [PORTS-1:0][7:0] dir,
  output logic [PULLS-1:0][7:0] pull
);

  if (PORTS != NUM_PORTS || PULLS > PORTS) begin : g_check
    $error("port_bank: port counts do not match the map");
  end

  typedef struct packed {
    logic [PORTS-1:0][7:0] data;
    logic [PORTS-1:0][7:0] dir;
    logic [PULLS-1:0][7:0] pull;
  } bank_t;

  bank_t q, d;

  always_comb begin
    logic [3:0] dSlot;
    logic [3:0] rSlot;
    dSlot = portSlot(req.addr - ADDR_DATA0);
    rSlot = portSlot(req.addr - ADDR_DIR0);
    d = q;
    if (req.wr) begin
      if (dSlot != SLOT_NONE) begin
        d.data[dSlot] = req.wdata;
      end
      if (rSlot != SLOT_NONE) begin
        d.dir[rSlot] = req.wdata;
      end
      if (req.addr >= ADDR_PULL0 && req.addr < ADDR_PULL0 + 8'(PULLS)) begin
        d.pull[2'(req.addr - ADDR_PULL0)] = req.wdata; // [RULE17]
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      q.data <= {PORTS{RST_DATA}};
      q.dir <= {PORTS{RST_DIR}};
      q.pull <= {PULLS{RST_PULL}};
    end else begin
      q <= d;
    end
  end

  assign data = q.data;
  assign dir = q.dir;
  assign pull = q.pull;

endmodule : port_bank
`default_nettype wire

// ==== ext_party.sv ====
// far-side model: memory and handshake partner on the multiplexed pins
`timescale 1ns/1ns
`default_nettype none
module ext_party
  import pinmux_pkg::*;
(
  input wire logic core_clk,
  input wire logic [NUM_PORTS-1:0][7:0] pinOut,
  input wire logic [NUM_PORTS-1:0][7:0] pinOe,
  input wire logic [NUM_PULL_PORTS-1:0][7:0] pullupEn,
  input wire logic hold,
  input wire logic rdy,
  input wire logic rxLevel,
  input wire logic [15:0] memWord,
  output logic [NUM_PORTS-1:0][7:0] pinIn
);
  // lines that no side drives or pulls up show the inverse of their last level, so no stale value passes
  logic [NUM_PORTS-1:0][7:0] lastQ = '0;
  logic [NUM_PORTS-1:0][7:0] farDrv;
  logic [NUM_PORTS-1:0][7:0] farEn;
  logic [NUM_PORTS-1:0][7:0] pullAll;

  always_comb begin
    farDrv = '0;
    farEn = '0;
    pullAll = '0;
    pullAll[NUM_PULL_PORTS-1:0] = pullupEn;
    farDrv[3][4] = hold;
    farDrv[3][6] = rdy;
    farEn[3] = 8'h50;
    // far clock source opposes the receive level so a released clock pin reads back distinct
    farDrv[4][3:1] = {rxLevel, rxLevel, ~rxLevel};
    farEn[4] = 8'h0E;
    farDrv[SLOT_PORT9] = {rxLevel, 1'b0, rxLevel, 5'h00};
    farEn[SLOT_PORT9] = 8'hA0;
    // memory answers only while the read strobe pin is driven high
    if (pinOe[3][1] && pinOut[3][1]) begin
      {farDrv[1], farDrv[0]} = memWord;
      {farEn[1], farEn[0]} = 16'hFFFF;
    end
    for (int p = 0; p < NUM_PORTS; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (pinOe[p][b]) begin
          pinIn[p][b] = pinOut[p][b];
        end else if (farEn[p][b]) begin
          pinIn[p][b] = farDrv[p][b];
        end else if (pullAll[p][b]) begin
          pinIn[p][b] = 1'b1;
        end else begin
          pinIn[p][b] = ~lastQ[p][b];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    lastQ <= pinIn;
  end
endmodule : ext_party
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench of the pin function multiplexer
`timescale 1ns/1ns
`default_nettype none
module testbench
  import pinmux_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] modeSel = 3'h3;
  logic standbyPin = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  ext_bus_t busOut = '0;
  periph_out_t periphOut = '0;
  periph_in_t periphIn;
  logic [NUM_PORTS-1:0][7:0] pinIn, pinOut, pinOe;
  logic [NUM_PULL_PORTS-1:0][7:0] pullupEn;
  logic standbyRequest, extBusActive;
  logic hold = 1'b1, rdy = 1'b0, rxLevel = 1'b0;
  logic [15:0] memWord = 16'h3CC3;
  int miscompares = 0, checked = 0, cycles = 0;

  pin_function_multiplexer DUT (.core_clk(core_clk), .rst_n(rst_n), .modeSel(modeSel),
    .standbyPin(standbyPin), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .busOut(busOut), .periphOut(periphOut),
    .periphIn(periphIn), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .pullupEn(pullupEn), .standbyRequest(standbyRequest), .extBusActive(extBusActive));

  ext_party party (.core_clk(core_clk), .pinOut(pinOut), .pinOe(pinOe), .pullupEn(pullupEn),
    .hold(hold), .rdy(rdy), .rxLevel(rxLevel), .memWord(memWord), .pinIn(pinIn));

  initial begin
    forever #10 core_clk = ~core_clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic test_done;
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    chk(regRdata, exp, what);
  endtask : rd

  task automatic boot(input logic [2:0] m);
    @(posedge core_clk);
    rst_n <= 1'b0;
    modeSel <= m;
    repeat (12) @(posedge core_clk);
    #1;
    chk(pinOe[0] | pinOe[3], 8'h00, "reset clears drive");
    @(posedge core_clk);
    rst_n <= 1'b1;
    tick(5);
  endtask : boot

  // ****************************************
  // scenarios
  // ****************************************
  task automatic single_chip;
    boot(3'h3);
    chk(8'(extBusActive), 8'h00, "single chip decode");
    rd(8'h13, RST_DIR, "dir reset");
    @(posedge core_clk);
    busOut <= '{adOut: 16'hFFFF, upperAddr: 8'hFF, default: 1'b1};
    wr(8'h10, 8'hF0);
    wr(ADDR_DATA0, 8'hA5);
    wr(8'h13, 8'hFF);
    wr(8'h03, 8'h3C);
    wr(ADDR_BUS_CTRL, 8'h3F);
    wr(ADDR_PULL0, 8'hFF);
    tick(2);
    chk(pinOut[0], 8'hA5, "p0 out");
    chk(pinOe[0], 8'hF0, "p0 oe");
    chk(pinOe[1], 8'h00, "p1 oe");
    chk(pinOe[2], 8'h00, "p2 oe");
    chk(pinOut[3], 8'h3C, "p3 out");
    chk(pinOe[3], 8'hFF, "p3 oe");
    chk(pullupEn[0], 8'h0F, "pullup inputs only");
    rd(ADDR_DATA0, 8'hAF, "p0 read mix");
    rd(ADDR_BUS_CTRL, 8'h00, "write only reg");
    rd(8'h50, 8'h00, "unmapped");
  endtask : single_chip

  task automatic serial_can;
    @(posedge core_clk);
    periphOut <= '{ser0ClkOut: 1'b0, default: 1'b1};
    rxLevel <= 1'b1;
    tick(3);
    chk(pinOe[4], 8'h03, "serial oe");
    chk(pinOut[4] & 8'h03, 8'h01, "serial out");
    chk(pinOe[SLOT_PORT9], 8'h40, "can oe");
    chk(pinOut[SLOT_PORT9], 8'h40, "can out");
    chk(8'({periphIn.ser0ClkIn, periphIn.ser0RxIn, periphIn.ser1RxIn, periphIn.can0Rx,
      periphIn.can1Rx}), 8'h0F, "rx taps high");
    @(posedge core_clk);
    periphOut <= '{ser0TxEn: 1'b0, ser0ClkEn: 1'b0, can1TxEn: 1'b0, default: 1'b1};
    rxLevel <= 1'b0;
    tick(3);
    chk(pinOe[4], 8'h00, "serial released");
    chk(pinOe[SLOT_PORT9], 8'h00, "can released");
    chk(8'({periphIn.ser0ClkIn, periphIn.ser0RxIn, periphIn.ser1RxIn, periphIn.can0Rx,
      periphIn.can1Rx}), 8'h10, "rx taps low");
    @(posedge core_clk);
    standbyPin <= 1'b1;
    tick(2);
    chk(8'(standbyRequest), 8'h01, "standby set");
    @(posedge core_clk);
    standbyPin <= 1'b0;
    tick(2);
    chk(8'(standbyRequest), 8'h00, "standby clear");
  endtask : serial_can

  task automatic external_bus;
    // bus-control settings against port 3 drive and the hold/ready taps
    logic [7:0] ctl [6] = '{8'h00, 8'h15, 8'h1D, 8'h1F, 8'h3D, 8'h3F};
    logic [7:0] oeExp [6] = '{8'h03, 8'hA7, 8'hA7, 8'hA7, 8'hA7, 8'hAF};
    logic [7:0] outExp [6] = '{8'h01, 8'hA5, 8'hA5, 8'hA5, 8'hA5, 8'hAD};
    logic [7:0] tapExp [6] = '{8'h01, 8'h03, 8'h02, 8'h02, 8'h02, 8'h02};
    boot(3'h0);
    chk(8'(extBusActive), 8'h01, "bus mode decode");
    @(posedge core_clk);
    busOut <= '{adOut: 16'hA55A, upperAddr: 8'hC3, readStrobe: 1'b0, default: 1'b1};
    wr(8'h12, 8'hFF);
    wr(8'h02, 8'h05);
    wr(ADDR_HIGH_ADDR_EN, 8'h0F);
    tick(2);
    chk(pinOut[0], 8'h5A, "bus low out");
    chk(pinOe[0], 8'hFF, "bus low oe");
    chk(pinOut[1], 8'hA5, "bus high out");
    chk(pinOe[1], 8'hFF, "bus high oe");
    chk(pinOut[2], 8'hC5, "upper addr mix");
    chk(pinOe[2], 8'hFF, "upper addr oe");
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_BUS_CTRL, ctl[i]);
      tick(3);
      chk(pinOe[3], oeExp[i], "p3 strobe oe");
      chk(pinOut[3], outExp[i], "p3 strobe out");
      chk(8'({periphIn.holdRequest, periphIn.readyIn}), tapExp[i], "hold ready");
    end
    // flip the far-side levels so the taps must follow the pins, not a constant
    @(posedge core_clk);
    hold <= 1'b0;
    rdy <= 1'b1;
    tick(3);
    chk(8'({periphIn.holdRequest, periphIn.readyIn}), 8'h01, "hold pins");
    @(posedge core_clk);
    busOut <= '{adOut: 16'h0000, adOe: 1'b0, upperAddr: 8'hC3, default: 1'b1};
    tick(3);
    chk(pinOe[0], 8'h00, "bus turned round");
    chk(periphIn.adIn[7:0], 8'hC3, "read low byte");
    chk(periphIn.adIn[15:8], 8'h3C, "read high byte");
  endtask : external_bus

  // ****************************************
  // run control
  // ****************************************
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      test_done();
    end
  end

  initial begin
    single_chip();
    serial_can();
    external_bus();
    test_done();
  end
endmodule : testbench
`default_nettype wire
